// ===== rtl/ccs_pkg.sv
// package for the common command and status logic
package ccs_pkg;

    // apb register byte offsets
    localparam logic [7:0] OFF_CMD = 8'h00;
    localparam logic [7:0] OFF_OUTQ = 8'h04;
    localparam logic [7:0] OFF_STB = 8'h08;
    localparam logic [7:0] OFF_SETTINGS = 8'h0c;
    localparam logic [7:0] OFF_INT_STAT = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;
    localparam logic [7:0] OFF_ERR = 8'h18;
    localparam logic [7:0] OFF_MASKS = 8'h1c;

    // command codes written to the op field of the command register
    localparam logic [3:0] OP_CLS = 4'h1;
    localparam logic [3:0] OP_ESE = 4'h2;
    localparam logic [3:0] OP_ESEQ = 4'h3;
    localparam logic [3:0] OP_ESRQ = 4'h4;
    localparam logic [3:0] OP_IDNQ = 4'h5;
    localparam logic [3:0] OP_OPC = 4'h6;
    localparam logic [3:0] OP_OPCQ = 4'h7;
    localparam logic [3:0] OP_RCL = 4'h8;
    localparam logic [3:0] OP_RST = 4'h9;
    localparam logic [3:0] OP_SAV = 4'ha;
    localparam logic [3:0] OP_SRE = 4'hb;
    localparam logic [3:0] OP_SREQ = 4'hc;
    localparam logic [3:0] OP_STBQ = 4'hd;

    // command register layout, pwdata[16:0]
    typedef struct packed {
        logic nl;
        logic [7:0] arg;
        logic [3:0] rsvd;
        logic [3:0] op;
    } ccs_cmd_type;
    localparam int CMD_W = 17;

    // status byte bits
    localparam int STB_OSS = 7;
    localparam int STB_MSS = 6;
    localparam int STB_ESB = 5;
    localparam int STB_MAV = 4;
    localparam int STB_CHANNEL_SUMMARY_BIT = 2;

    // standard event register bits and power-on value
    localparam int ESR_OPC = 0;
    localparam int ESR_QYE = 2;
    localparam int ESR_EXE = 4;
    localparam int ESR_CME = 5;
    localparam logic [7:0] ESR_RST = 8'h80;

    // error codes kept for the clear-status command
    localparam logic [7:0] ERR_NONE = 8'h00;
    localparam logic [7:0] ERR_CMD = 8'h01;
    localparam logic [7:0] ERR_EXEC = 8'h02;
    localparam logic [7:0] ERR_QUERY = 8'h03;

    // interrupt status bits
    localparam int INT_W = 4;
    localparam int INT_DONE = 0;
    localparam int INT_ERR = 1;
    localparam int INT_MSS = 2;
    localparam int INT_OPC = 3;

    // storage sizes
    localparam logic [15:0] SET_DEFAULT = 16'h0000;
    localparam int SAVE_SLOTS = 4;
    localparam int QPTR_W = 4;
    localparam int QDEPTH = 16;
    localparam int IDX_W = 5;

    // ascii
    localparam logic [7:0] ASCII_ZERO = 8'h30;
    localparam logic [7:0] ASCII_NL = 8'h0a;

    // identity string, value arbitrary
    localparam int IDN_LEN = 18;
    localparam logic [8*IDN_LEN-1:0] IDN_TEXT = "VENDOR,MODEL,0,1.0";

endpackage

// ===== rtl/ccs_resp_gen.sv
// response generator: decimal value or identity string, newline ended
`timescale 1ns/100ps
module ccs_resp_gen (
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // request
    input wire logic start,
    input wire logic idn_sel,
    input wire logic [7:0] value,
    // byte stream
    input wire logic out_ready,
    output logic out_valid,
    output logic [7:0] out_byte,
    output logic busy
);
    logic busy_r;
    logic idn_r;
    logic [ccs_pkg::IDX_W-1:0] idx_r;
    logic [ccs_pkg::IDX_W-1:0] len_r;
    logic [23:0] dig_r;
    logic [7:0] byte_r;
    logic [23:0] dig_new;
    logic [ccs_pkg::IDX_W-1:0] len_new;
    logic [7:0] d_hun;
    logic [7:0] d_ten;
    logic [7:0] d_one;

    function automatic logic [7:0] byte_pick(
        input logic idn,
        input logic [ccs_pkg::IDX_W-1:0] idx,
        input logic [ccs_pkg::IDX_W-1:0] len,
        input logic [23:0] dig
    );
        logic [7:0] b;
        b = ccs_pkg::ASCII_NL;
        if (idx != len - 1'b1) begin
            if (idn) begin
                b = ccs_pkg::IDN_TEXT[8*(ccs_pkg::IDN_LEN-1-int'(idx)) +: 8];
            end else begin
                b = dig[23-8*int'(idx) -: 8];
            end
        end
        return b;
    endfunction

    // leading zeros are suppressed, so 0 still yields one digit
    always_comb begin
        d_hun = ccs_pkg::ASCII_ZERO + value / 8'h64;
        d_ten = ccs_pkg::ASCII_ZERO + (value / 8'h0a) % 8'h0a;
        d_one = ccs_pkg::ASCII_ZERO + value % 8'h0a;
        if (idn_sel) begin
            dig_new = 24'h000000;
            len_new = idx_cast(ccs_pkg::IDN_LEN + 1);
        end else if (value >= 8'h64) begin
            dig_new = {d_hun, d_ten, d_one};
            len_new = 5'h04;
        end else if (value >= 8'h0a) begin
            dig_new = {d_ten, d_one, 8'h00};
            len_new = 5'h03;
        end else begin
            dig_new = {d_one, 16'h0000};
            len_new = 5'h02;
        end
    end

    function automatic logic [ccs_pkg::IDX_W-1:0] idx_cast(input int n);
        return n[ccs_pkg::IDX_W-1:0];
    endfunction

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
            idn_r <= 1'b0;
            idx_r <= '0;
            len_r <= '0;
            dig_r <= 24'h000000;
            byte_r <= 8'h00;
        end else if (start) begin
            busy_r <= 1'b1;
            idn_r <= idn_sel;
            dig_r <= dig_new;
            len_r <= len_new;
            idx_r <= '0;
            byte_r <= byte_pick(idn_sel, '0, len_new, dig_new);
        end else if (busy_r && out_ready) begin
            if (idx_r == len_r - 1'b1) begin
                busy_r <= 1'b0;
            end else begin
                idx_r <= idx_r + 1'b1;
                byte_r <= byte_pick(idn_r, idx_r + 1'b1, len_r, dig_r);
            end
        end
    end

    assign out_valid = busy_r;
    assign out_byte = byte_r;
    assign busy = busy_r;
endmodule

// ===== rtl/ccs_top.sv
// common command and status logic with apb register access
// What this block does
// - clear status wipes error code; with newline also flushes output queue
// - event enable loads an 8-bit mask, one bit per standard event
// - enabled standard events ORed into event summary, status bit 5
// - mask value 48 enables command and execution error events
// - event enable query returns the mask unchanged
// - event register query returns contents then clears register
// - identify query returns maker, model, serial, firmware, comma separated
// - operation complete sets event bit 0 once nothing is pending
// - operation complete query answers ascii 1 only after completion
// - recall restores settings stored earlier at the given slot
// - save stores present settings into the given slot
// - service request enable loads an 8-bit status byte mask
// - enabled status byte bits ORed into master summary, bit 6
// - mask value 20 enables channel summary and message available
// - message available set while output queue holds data
// - status byte query shows master summary, never clears the byte
`timescale 1ns/100ps
module ccs_top (
    // clock and reset
    input wire logic CORE_CLK,
    input wire logic NRST,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // device side, same clock domain
    input wire logic OP_BUSY,
    input wire logic OPER_SUM,
    input wire logic CHAN_SUM,
    output logic [15:0] SETTINGS,
    output logic [7:0] STATUS_BYTE,
    // interrupt
    output logic IRQ
);
    typedef enum logic [0:0] {ST_IDLE, ST_WAIT_OPC} ccs_state_type;

    ccs_state_type state_r, state_nxt;
    ccs_pkg::ccs_cmd_type cmd;
    logic [7:0] ese_r, sre_r, esr_r, esr_nxt, esr_set, stb_r, stb_nxt;
    logic [7:0] err_r, gen_val, q_head, gen_byte;
    logic [15:0] settings_r;
    logic [15:0] save_mem [ccs_pkg::SAVE_SLOTS];
    logic [7:0] q_mem [ccs_pkg::QDEPTH];
    logic [ccs_pkg::QPTR_W:0] wr_ptr_r, rd_ptr_r;
    logic [ccs_pkg::INT_W-1:0] int_stat_r, int_mask_r, int_ev, int_clr;
    logic [31:0] prdata_r;
    logic pslverr_r, irq_r, opc_arm_r, gen_busy_d_r;
    logic setup, wr_acc, rd_acc, cmd_go, busy, refuse;
    logic op_cls, op_ese, op_eseq, op_esrq, op_idnq, op_opc, op_opcq;
    logic op_rcl, op_rst, op_sav, op_sre, op_sreq, op_stbq;
    logic ev_cme, ev_exe, ev_qye, opc_fire, slot_bad, mss;
    logic gen_start, gen_idn, gen_valid, gen_busy, gen_ready;
    logic q_empty, q_full, push, pop, flush;
    logic [1:0] slot;

    function automatic logic addr_known(input logic [7:0] a);
        return a == ccs_pkg::OFF_CMD || a == ccs_pkg::OFF_OUTQ ||
            a == ccs_pkg::OFF_STB || a == ccs_pkg::OFF_SETTINGS ||
            a == ccs_pkg::OFF_INT_STAT || a == ccs_pkg::OFF_INT_MASK ||
            a == ccs_pkg::OFF_ERR || a == ccs_pkg::OFF_MASKS;
    endfunction

    function automatic logic op_known(input logic [3:0] op);
        return op >= ccs_pkg::OP_CLS && op <= ccs_pkg::OP_STBQ;
    endfunction

    // bus phases; a refused access never takes effect
    assign setup = PSEL && !PENABLE;
    assign wr_acc = PSEL && PENABLE && PWRITE && !pslverr_r;
    assign rd_acc = PSEL && PENABLE && !PWRITE && !pslverr_r;
    assign busy = (state_r != ST_IDLE) || gen_busy;
    assign refuse = !addr_known(PADDR) ||
        (PWRITE && PADDR == ccs_pkg::OFF_CMD && busy);

    // one command word stands for one star-prefixed host command
    assign cmd = ccs_pkg::ccs_cmd_type'(PWDATA[ccs_pkg::CMD_W-1:0]);
    assign cmd_go = wr_acc && PADDR == ccs_pkg::OFF_CMD;
    assign op_cls = cmd_go && cmd.op == ccs_pkg::OP_CLS;
    assign op_ese = cmd_go && cmd.op == ccs_pkg::OP_ESE;
    assign op_eseq = cmd_go && cmd.op == ccs_pkg::OP_ESEQ;
    assign op_esrq = cmd_go && cmd.op == ccs_pkg::OP_ESRQ;
    assign op_idnq = cmd_go && cmd.op == ccs_pkg::OP_IDNQ;
    assign op_opc = cmd_go && cmd.op == ccs_pkg::OP_OPC;
    assign op_opcq = cmd_go && cmd.op == ccs_pkg::OP_OPCQ;
    assign op_rcl = cmd_go && cmd.op == ccs_pkg::OP_RCL;
    assign op_rst = cmd_go && cmd.op == ccs_pkg::OP_RST;
    assign op_sav = cmd_go && cmd.op == ccs_pkg::OP_SAV;
    assign op_sre = cmd_go && cmd.op == ccs_pkg::OP_SRE;
    assign op_sreq = cmd_go && cmd.op == ccs_pkg::OP_SREQ;
    assign op_stbq = cmd_go && cmd.op == ccs_pkg::OP_STBQ;

    assign slot_bad = cmd.arg >= 8'(ccs_pkg::SAVE_SLOTS);
    assign slot = cmd.arg[1:0];
    assign ev_cme = cmd_go && !op_known(cmd.op);
    assign ev_exe = (op_sav || op_rcl) && slot_bad;
    assign ev_qye = rd_acc && PADDR == ccs_pkg::OFF_OUTQ && q_empty;
    assign opc_fire = opc_arm_r && !OP_BUSY;

    // queries hand a value to the generator; identity uses its string
    assign gen_start = op_eseq || op_esrq || op_idnq || op_sreq ||
        op_stbq || (state_r == ST_WAIT_OPC && !OP_BUSY);
    assign gen_idn = op_idnq;
    always_comb begin
        gen_val = 8'h01;
        if (op_eseq) begin
            gen_val = ese_r;
        end else if (op_esrq) begin
            gen_val = esr_r;
        end else if (op_sreq) begin
            gen_val = sre_r;
        end else if (op_stbq) begin
            gen_val = stb_r;
        end
    end

    ccs_resp_gen u_gen (
        .core_clk(CORE_CLK),
        .nrst(NRST),
        .start(gen_start),
        .idn_sel(gen_idn),
        .value(gen_val),
        .out_ready(gen_ready),
        .out_valid(gen_valid),
        .out_byte(gen_byte),
        .busy(gen_busy)
    );

    // opc? waits here while operations are pending
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (op_opcq) begin
                    state_nxt = ST_WAIT_OPC;
                end
            end
            ST_WAIT_OPC: begin
                if (!OP_BUSY) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            opc_arm_r <= 1'b0;
        end else if (op_opc) begin
            opc_arm_r <= 1'b1;
        end else if (opc_fire) begin
            opc_arm_r <= 1'b0;
        end
    end

    // enable masks; reset command leaves them alone
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            ese_r <= 8'h00;
            sre_r <= 8'h00;
        end else begin
            if (op_ese) begin
                ese_r <= cmd.arg;
            end
            if (op_sre) begin
                sre_r <= cmd.arg;
            end
        end
    end

    // event register: a set in the clearing cycle survives
    always_comb begin
        esr_set = 8'h00;
        esr_set[ccs_pkg::ESR_OPC] = opc_fire;
        esr_set[ccs_pkg::ESR_QYE] = ev_qye;
        esr_set[ccs_pkg::ESR_EXE] = ev_exe;
        esr_set[ccs_pkg::ESR_CME] = ev_cme;
        esr_nxt = (op_esrq ? 8'h00 : esr_r) | esr_set;
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            esr_r <= ccs_pkg::ESR_RST;
        end else begin
            esr_r <= esr_nxt;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            err_r <= ccs_pkg::ERR_NONE;
        end else if (ev_cme) begin
            err_r <= ccs_pkg::ERR_CMD;
        end else if (ev_exe) begin
            err_r <= ccs_pkg::ERR_EXEC;
        end else if (ev_qye) begin
            err_r <= ccs_pkg::ERR_QUERY;
        end else if (op_cls) begin
            err_r <= ccs_pkg::ERR_NONE;
        end
    end

    // settings and save slots
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            settings_r <= ccs_pkg::SET_DEFAULT;
        end else if (op_rst) begin
            settings_r <= ccs_pkg::SET_DEFAULT;
        end else if (op_rcl && !slot_bad) begin
            settings_r <= save_mem[slot];
        end else if (wr_acc && PADDR == ccs_pkg::OFF_SETTINGS) begin
            settings_r <= PWDATA[15:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < ccs_pkg::SAVE_SLOTS; i++) begin
                save_mem[i] <= ccs_pkg::SET_DEFAULT;
            end
        end else if (op_sav && !slot_bad) begin
            save_mem[slot] <= settings_r;
        end
    end

    // output queue; a full queue stalls the generator
    assign q_empty = wr_ptr_r == rd_ptr_r;
    assign q_full = wr_ptr_r == {~rd_ptr_r[ccs_pkg::QPTR_W],
        rd_ptr_r[ccs_pkg::QPTR_W-1:0]};
    assign gen_ready = !q_full;
    assign push = gen_valid && !q_full;
    assign pop = rd_acc && PADDR == ccs_pkg::OFF_OUTQ && !q_empty;
    assign flush = op_cls && cmd.nl;
    // an empty queue reads as zero, never a stale or unwritten entry
    assign q_head = q_empty ? 8'h00 :
        q_mem[rd_ptr_r[ccs_pkg::QPTR_W-1:0]];

    always_ff @(posedge CORE_CLK) begin
        if (push) begin
            q_mem[wr_ptr_r[ccs_pkg::QPTR_W-1:0]] <= gen_byte;
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
        end else if (flush) begin
            rd_ptr_r <= wr_ptr_r;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
        end
    end

    // status byte; bits follow their sources, reading never clears
    always_comb begin
        stb_nxt = 8'h00;
        stb_nxt[ccs_pkg::STB_OSS] = OPER_SUM;
        stb_nxt[ccs_pkg::STB_ESB] = |(esr_r & ese_r);
        stb_nxt[ccs_pkg::STB_MAV] = !q_empty;
        stb_nxt[ccs_pkg::STB_CHANNEL_SUMMARY_BIT] = CHAN_SUM;
        mss = |(stb_nxt & sre_r);
        stb_nxt[ccs_pkg::STB_MSS] = mss;
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            stb_r <= 8'h00;
        end else begin
            stb_r <= stb_nxt;
        end
    end

    // interrupts: sticky, write one to clear, set wins
    always_comb begin
        int_ev = '0;
        int_ev[ccs_pkg::INT_DONE] = gen_busy_d_r && !gen_busy;
        int_ev[ccs_pkg::INT_ERR] = ev_cme || ev_exe || ev_qye;
        int_ev[ccs_pkg::INT_MSS] = mss && !stb_r[ccs_pkg::STB_MSS];
        int_ev[ccs_pkg::INT_OPC] = opc_fire;
        int_clr = '0;
        if (wr_acc && PADDR == ccs_pkg::OFF_INT_STAT) begin
            int_clr = PWDATA[ccs_pkg::INT_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            int_stat_r <= '0;
            int_mask_r <= '0;
            gen_busy_d_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
            gen_busy_d_r <= gen_busy;
            irq_r <= |(int_stat_r & int_mask_r);
            if (wr_acc && PADDR == ccs_pkg::OFF_INT_MASK) begin
                int_mask_r <= PWDATA[ccs_pkg::INT_W-1:0];
            end
        end
    end

    // read data and error are fixed in the setup cycle
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            prdata_r <= 32'h00000000;
            pslverr_r <= 1'b0;
        end else if (setup) begin
            pslverr_r <= refuse;
            case (PADDR)
                ccs_pkg::OFF_CMD: prdata_r <= {31'h0, busy};
                ccs_pkg::OFF_OUTQ: prdata_r <= {23'h0, !q_empty, q_head};
                ccs_pkg::OFF_STB: prdata_r <= {24'h0, stb_r};
                ccs_pkg::OFF_SETTINGS: prdata_r <= {16'h0, settings_r};
                ccs_pkg::OFF_INT_STAT: prdata_r <= {28'h0, int_stat_r};
                ccs_pkg::OFF_INT_MASK: prdata_r <= {28'h0, int_mask_r};
                ccs_pkg::OFF_ERR: prdata_r <= {24'h0, err_r};
                ccs_pkg::OFF_MASKS: prdata_r <= {16'h0, sre_r, ese_r};
                default: prdata_r <= 32'h00000000;
            endcase
        end
    end

    assign PRDATA = prdata_r;
    assign PREADY = 1'b1;
    assign PSLVERR = pslverr_r && PSEL && PENABLE;
    assign SETTINGS = settings_r;
    assign STATUS_BYTE = stb_r;
    assign IRQ = irq_r;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    sequence s_opcq_taken;
        op_opcq ##1 (state_r == ST_WAIT_OPC);
    endsequence
    sequence s_arm_pending;
        opc_arm_r && !OP_BUSY;
    endsequence

    a_ese_load: assert property (op_ese |=> ese_r == $past(cmd.arg))
        else $error("event enable mask not loaded");
    a_sre_load: assert property (op_sre |=> sre_r == $past(cmd.arg))
        else $error("request enable mask not loaded");
    a_esb_summary: assert property (
        stb_r[ccs_pkg::STB_ESB] == $past(|(esr_r & ese_r)))
        else $error("event summary wrong");
    a_mss_summary: assert property (
        stb_r[ccs_pkg::STB_MSS] ==
        |(stb_r & ~(8'h01 << ccs_pkg::STB_MSS) & $past(sre_r)))
        else $error("master summary wrong");
    a_mav_level: assert property (
        stb_r[ccs_pkg::STB_MAV] == $past(!q_empty))
        else $error("message available wrong");
    a_esr_clear: assert property (op_esrq |=> esr_r == $past(esr_set))
        else $error("event register not cleared by query");
    a_opc_sets: assert property (
        s_arm_pending |=> esr_r[ccs_pkg::ESR_OPC])
        else $error("operation complete bit not set");
    a_opcq_waits: assert property (
        s_opcq_taken ##0 OP_BUSY |-> !gen_start)
        else $error("opc query answered while busy");
    a_cls_flush: assert property (flush |=> q_empty)
        else $error("clear status left queue data");
    a_rst_default: assert property (
        op_rst |=> settings_r == ccs_pkg::SET_DEFAULT && $stable(ese_r))
        else $error("reset did not restore settings");
    a_sav_rcl: assert property (
        op_rcl && !slot_bad |=> settings_r == $past(save_mem[slot]))
        else $error("recall did not restore slot");
endmodule

// ===== verif/ccs_host_model.sv
// host controller model: apb master that forms and issues commands
`timescale 1ns/100ps
module ccs_host_model (
    // clock
    input wire logic clk,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    int hangs = 0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // the request stands until pready is seen high at a rising edge, or 50 more edges pass;
    // read data and error are taken at that same edge, then released
    task automatic xfer(input logic wr, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        for (n = 0; n < 50 && pready !== 1'b1; n++) begin
            @(posedge clk);
        end
        if (pready !== 1'b1) begin
            hangs++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic issue(input logic [3:0] op, input logic [7:0] arg,
            input logic nl);
        ccs_pkg::ccs_cmd_type c;
        logic [31:0] r;
        logic e;
        c = '{nl: nl, arg: arg, rsvd: 4'h0, op: op};
        xfer(1'b1, ccs_pkg::OFF_CMD, {15'h0, c}, r, e);
    endtask
    // poll busy; a command written while busy would be refused
    task automatic settle();
        logic [31:0] r;
        logic e;
        r = 32'h1;
        for (int n = 0; n < 200 && r[0] !== 1'b0; n++) begin
            xfer(1'b0, ccs_pkg::OFF_CMD, 32'h0, r, e);
        end
        if (r[0] !== 1'b0) begin
            hangs++;
        end
    endtask
endmodule

// ===== verif/common_command_status_logic_test.sv
// testbench: command sequences over apb against the command logic
`timescale 1ns/100ps
module common_command_status_logic_test;
    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    logic op_busy = 1'b0;
    logic oper_sum = 1'b0;
    logic chan_sum = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, stb;
    logic [31:0] pwdata, prdata;
    logic [15:0] settings;
    int errors = 0;
    int comparisons = 0;
    always #10 core_clk = ~core_clk;
    ccs_top u_dut (.CORE_CLK(core_clk), .NRST(nrst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .OP_BUSY(op_busy), .OPER_SUM(oper_sum),
        .CHAN_SUM(chan_sum), .SETTINGS(settings), .STATUS_BYTE(stb),
        .IRQ(irq));
    ccs_host_model u_host (.clk(core_clk), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b0, a, 32'h0, r, e);
        check(r, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        u_host.xfer(1'b1, a, d, r, e);
    endtask
    task automatic cmd(input logic [3:0] op, input logic [7:0] arg = 8'h0);
        u_host.issue(op, arg, 1'b1);
        u_host.settle();
    endtask
    // each byte must arrive flagged valid, in order, newline last
    task automatic text(input string s);
        for (int i = 0; i < s.len(); i++) begin
            rd(ccs_pkg::OFF_OUTQ, {23'h0, 1'b1, s[i]});
        end
    endtask
    task automatic summarize();
        errors += u_host.hangs;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        logic [31:0] r;
        logic e;
        repeat (8) @(posedge core_clk);
        nrst <= 1'b1;
        cmd(ccs_pkg::OP_ESE, 8'd48);
        cmd(ccs_pkg::OP_ESEQ);
        text("48\n");
        rd(ccs_pkg::OFF_MASKS, 32'h30);
        rd(ccs_pkg::OFF_STB, 32'h0);
        cmd(4'hf);
        rd(ccs_pkg::OFF_STB, 32'h20);
        cmd(ccs_pkg::OP_ESRQ);
        text("160\n");
        rd(ccs_pkg::OFF_STB, 32'h0);
        u_host.issue(ccs_pkg::OP_CLS, 8'h0, 1'b0);
        u_host.settle();
        rd(ccs_pkg::OFF_ERR, 32'h0);
        cmd(ccs_pkg::OP_SRE, 8'd20);
        chan_sum <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(ccs_pkg::OFF_STB, 32'h44);
        rd(ccs_pkg::OFF_STB, 32'h44);
        check({24'h0, stb}, 32'h44);
        cmd(ccs_pkg::OP_STBQ);
        text("68\n");
        chan_sum <= 1'b0;
        oper_sum <= 1'b1;
        repeat (3) @(posedge core_clk);
        rd(ccs_pkg::OFF_STB, 32'h80);
        oper_sum <= 1'b0;
        cmd(ccs_pkg::OP_SREQ);
        rd(ccs_pkg::OFF_STB, 32'h50);
        text("20\n");
        rd(ccs_pkg::OFF_STB, 32'h0);
        cmd(ccs_pkg::OP_ESEQ);
        cmd(ccs_pkg::OP_CLS);
        rd(ccs_pkg::OFF_OUTQ, 32'h0);
        // longer than the queue: drained while it is still produced
        u_host.issue(ccs_pkg::OP_IDNQ, 8'h0, 1'b1);
        text("VENDOR,MODEL,0,1.0\n");
        cmd(ccs_pkg::OP_ESRQ);
        text("4\n");
        op_busy <= 1'b1;
        u_host.issue(ccs_pkg::OP_OPC, 8'h0, 1'b1);
        cmd(ccs_pkg::OP_ESRQ);
        text("0\n");
        op_busy <= 1'b0;
        repeat (3) @(posedge core_clk);
        cmd(ccs_pkg::OP_ESRQ);
        text("1\n");
        op_busy <= 1'b1;
        u_host.issue(ccs_pkg::OP_OPCQ, 8'h0, 1'b1);
        repeat (20) @(posedge core_clk);
        rd(ccs_pkg::OFF_CMD, 32'h1);
        rd(ccs_pkg::OFF_STB, 32'h0);
        u_host.xfer(1'b1, ccs_pkg::OFF_CMD, 32'h2, r, e);
        check({31'h0, e}, 32'h1);
        op_busy <= 1'b0;
        u_host.settle();
        text("1\n");
        wr(ccs_pkg::OFF_SETTINGS, 32'h1234);
        cmd(ccs_pkg::OP_SAV, 8'h1);
        wr(ccs_pkg::OFF_SETTINGS, 32'h00ff);
        cmd(ccs_pkg::OP_RST);
        rd(ccs_pkg::OFF_SETTINGS, {16'h0, ccs_pkg::SET_DEFAULT});
        rd(ccs_pkg::OFF_MASKS, 32'h1430);
        cmd(ccs_pkg::OP_RCL, 8'h1);
        rd(ccs_pkg::OFF_SETTINGS, 32'h1234);
        check({16'h0, settings}, 32'h1234);
        cmd(ccs_pkg::OP_SAV, 8'h4);
        rd(ccs_pkg::OFF_ERR, 32'h2);
        wr(ccs_pkg::OFF_INT_STAT, 32'hf);
        wr(ccs_pkg::OFF_INT_MASK, 32'h0);
        cmd(ccs_pkg::OP_ESEQ);
        rd(ccs_pkg::OFF_INT_STAT, 32'h5);
        check({31'h0, irq}, 32'h0);
        wr(ccs_pkg::OFF_INT_MASK, 32'h1);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h1);
        text("48\n");
        wr(ccs_pkg::OFF_INT_STAT, 32'hf);
        repeat (2) @(posedge core_clk);
        check({31'h0, irq}, 32'h0);
        u_host.xfer(1'b0, 8'h20, 32'h0, r, e);
        check({31'h0, e}, 32'h1);
        summarize();
    end
endmodule
